// ==== logic/isr_cfg.svh ====
// Constants for the instrument status reporting block
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH
// Questionable condition bit positions
`define ISR_Q_OVERV 0
`define ISR_Q_OVERI 1
`define ISR_Q_PWRFAIL 2
`define ISR_Q_OVERT 4
`define ISR_Q_INHIBIT 9
`define ISR_Q_UNREG 10
`define ISR_Q_DEFINED 16'h0617
// Standard event bit positions
`define ISR_E_PWRON 7
`define ISR_E_CMDERR 5
`define ISR_E_EXECERR 4
`define ISR_E_DEVERR 3
`define ISR_E_QRYERR 2
`define ISR_E_DONE 0
`define ISR_E_DEFINED 8'hBD
// Status byte bit positions
`define ISR_S_OPSUM 7
`define ISR_S_MASTER 6
`define ISR_S_EVSUM 5
`define ISR_S_MSGAV 4
`define ISR_S_QSUM 3
`define ISR_S_ERR 2
// Preset and reset values
`define ISR_PRE_FALL 16'h0000
`define ISR_PRE_RISE 16'h7FFF
`define ISR_PRE_QEN 16'h0000
`define ISR_RST_ESR 8'h80
// Error queue
`define ISR_EQ_DEPTH 8
`define ISR_EQ_AW 3
`define ISR_ERR_NONE 16'h0000
`define ISR_ERR_OVF 16'hFEA2
`define ISR_ASCII_ONE 16'h0031
`endif

// ==== logic/isr_pkg.sv ====
// Types for the instrument status reporting block
package isr_pkg;
  typedef enum logic [4:0] {
    ISR_NOP = 5'h00, ISR_RD_COND = 5'h01, ISR_RD_QEVT = 5'h02, ISR_WR_QEN = 5'h03,
    ISR_RD_QEN = 5'h04, ISR_WR_FALL = 5'h05, ISR_RD_FALL = 5'h06, ISR_WR_RISE = 5'h07,
    ISR_RD_RISE = 5'h08, ISR_PRESET = 5'h09, ISR_CLS = 5'h0A, ISR_WR_ESE = 5'h0B,
    ISR_RD_ESE = 5'h0C, ISR_RD_ESR = 5'h0D, ISR_CPL = 5'h0E, ISR_CPL_Q = 5'h0F,
    ISR_WR_SRE = 5'h10, ISR_RD_SRE = 5'h11, ISR_RD_STB = 5'h12, ISR_POLL = 5'h13,
    ISR_WAI = 5'h14, ISR_RD_ERR = 5'h15, ISR_WR_RL = 5'h16, ISR_RD_RL = 5'h17
  } isr_op_t;
  typedef enum logic [1:0] {
    ISR_LOCAL = 2'h0, ISR_REMOTE = 2'h1, ISR_LOCKED = 2'h2
  } isr_rl_t;
  typedef enum logic [1:0] {
    ISR_ST_RUN = 2'h0, ISR_ST_WAI = 2'h1, ISR_ST_OPCQ = 2'h2
  } isr_st_t;
  typedef struct packed {
    isr_op_t op;
    logic after_term;
    logic [15:0] data;
  } isr_cmd_t;
  typedef struct packed {
    logic cmd_err;
    logic exec_err;
    logic dev_err;
    logic qry_err;
  } isr_err_evt_t;
endpackage : isr_pkg

// ==== logic/isr_status.sv ====
// Status byte, event groups, completion tracking, error queue, remote/local
//
// Operation
// - Questionable live state is read-only and shows present, unlatched sources.
// - Status byte bit 3 is OR of enabled questionable event bits.
// - Preset loads fall filter 0, rise filter 32767, questionable mask 0.
// - Fall filter bit one: a 1-to-0 change sets the event bit.
// - Rise filter bit one: a 0-to-1 change sets the event bit.
// - Both filter bits one latch any change; both zero latch none.
// - Clear-status zeroes standard, operation, questionable events, status byte, errors.
// - Clear-status after a terminator also flushes output queue and message bit.
// - Standard event bits: power-on 7, command 5, exec 4, device 3, query 2, complete 0.
// - Event summary is OR of enabled standard event bits.
// - Reading the standard event register returns it and clears it.
// - Complete command sets bit 0 once all pending work ends, without stalling.
// - Complete query blocks commands, then queues ASCII 1 when all work ends.
// - Master summary bit 6 is OR of enabled status byte bits.
// - Serial poll returns request flag at bit 6 and clears it only.
// - A zero service-request mask never raises a service request.
// - Status byte read changes nothing; summaries clear via their event registers.
// - Message bit clears at power-on, on clear-status, and when queue empties.
// - Status byte: operation 7, event 5, message 4, questionable 3, error 2.
// - Wait command blocks commands until work ends; only device clear aborts.
// - Remote/local is local at power-on; latest changer wins; lock disables keys.
// - Error FIFO pops one per read, empty gives 0, overflow ends in -350.
// - Questionable bits: overvoltage 0, overcurrent 1, power fail 2, overtemp 4, inhibit 9, unregulated 10.
// - Questionable event bits stay latched until read, the read clears them.
`timescale 1ns/1ps
`include "isr_cfg.svh"
module isr_status (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire isr_pkg::isr_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic [15:0] questionable_summary_src,
  input wire logic operation_summary,
  input wire logic pending_busy,
  input wire isr_pkg::isr_err_evt_t err_evt,
  input wire logic err_push,
  input wire logic [15:0] err_code,
  input wire logic oq_nonempty,
  input wire logic dev_clear,
  input wire logic rl_if_valid,
  input wire isr_pkg::isr_rl_t rl_if_state,
  output logic operation_summary_evt_clear,
  output logic oq_flush,
  output logic srq,
  output logic keys_locked,
  output isr_pkg::isr_rl_t rl_state
);

  function automatic logic any_en(input logic [15:0] v, input logic [15:0] m);
    any_en = |(v & m);
  endfunction : any_en

  // ****************************************
  // Command decode
  // ****************************************
  isr_pkg::isr_st_t st_ff;
  logic take;
  logic done_wait;
  assign cmd_ready = (st_ff == isr_pkg::ISR_ST_RUN);
  assign take = cmd_valid & cmd_ready;
  assign done_wait = ~pending_busy;

  function automatic logic is_op(input logic t, input isr_pkg::isr_cmd_t c,
                                 input isr_pkg::isr_op_t o);
    is_op = t & (c.op == o);
  endfunction : is_op

  logic do_cls;
  logic do_pre;
  logic rd_qevt;
  logic rd_esr;
  logic rd_err;
  logic do_poll;
  assign do_cls = is_op(take, cmd, isr_pkg::ISR_CLS);
  assign do_pre = is_op(take, cmd, isr_pkg::ISR_PRESET);
  assign rd_qevt = is_op(take, cmd, isr_pkg::ISR_RD_QEVT);
  assign rd_esr = is_op(take, cmd, isr_pkg::ISR_RD_ESR);
  assign rd_err = is_op(take, cmd, isr_pkg::ISR_RD_ERR);
  assign do_poll = is_op(take, cmd, isr_pkg::ISR_POLL);

  // ****************************************
  // Questionable group
  // ****************************************
  logic [15:0] cond;
  logic [15:0] cond_prev_ff;
  logic [15:0] fall_ff;
  logic [15:0] rise_ff;
  logic [15:0] qen_ff;
  logic [15:0] qevt_ff;
  logic [15:0] qset;
  assign cond = questionable_summary_src & `ISR_Q_DEFINED;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_edge
      assign qset[gi] = (fall_ff[gi] & cond_prev_ff[gi] & ~cond[gi]) |
                        (rise_ff[gi] & ~cond_prev_ff[gi] & cond[gi]);
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cond_prev_ff <= 16'h0000;
    else
      cond_prev_ff <= cond;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fall_ff <= `ISR_PRE_FALL;
      rise_ff <= `ISR_PRE_RISE;
      qen_ff <= `ISR_PRE_QEN;
    end
    else if (do_pre)
    begin
      fall_ff <= `ISR_PRE_FALL;
      rise_ff <= `ISR_PRE_RISE;
      qen_ff <= `ISR_PRE_QEN;
    end
    else if (take)
    begin
      if (cmd.op == isr_pkg::ISR_WR_FALL)
        fall_ff <= cmd.data & `ISR_Q_DEFINED;
      if (cmd.op == isr_pkg::ISR_WR_RISE)
        rise_ff <= cmd.data & `ISR_Q_DEFINED;
      if (cmd.op == isr_pkg::ISR_WR_QEN)
        qen_ff <= cmd.data & `ISR_Q_DEFINED;
    end
  end

  // New edges win over a read or clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      qevt_ff <= 16'h0000;
    else if (rd_qevt || do_cls)
      qevt_ff <= qset;
    else
      qevt_ff <= qevt_ff | qset;
  end

  // ****************************************
  // Standard event group
  // ****************************************
  logic [7:0] esr_ff;
  logic [7:0] ese_ff;
  logic [7:0] eset;
  logic cpl_armed_ff;
  logic cpl_fire;
  assign cpl_fire = cpl_armed_ff & done_wait;
  always_comb
  begin
    eset = 8'h00;
    eset[`ISR_E_CMDERR] = err_evt.cmd_err;
    eset[`ISR_E_EXECERR] = err_evt.exec_err;
    eset[`ISR_E_DEVERR] = err_evt.dev_err;
    eset[`ISR_E_QRYERR] = err_evt.qry_err;
    eset[`ISR_E_DONE] = cpl_fire;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      esr_ff <= `ISR_RST_ESR;
    else if (rd_esr || do_cls)
      esr_ff <= eset;
    else
      esr_ff <= esr_ff | eset;
  end

  // Arming does not block the command stream
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cpl_armed_ff <= 1'b0;
    else if (is_op(take, cmd, isr_pkg::ISR_CPL))
      cpl_armed_ff <= 1'b1;
    else if (done_wait)
      cpl_armed_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ese_ff <= 8'h00;
    else if (is_op(take, cmd, isr_pkg::ISR_WR_ESE))
      ese_ff <= cmd.data[7:0] & `ISR_E_DEFINED;
  end

  // ****************************************
  // Error queue
  // ****************************************
  logic [15:0] eq_mem [0:`ISR_EQ_DEPTH-1];
  logic [`ISR_EQ_AW-1:0] eq_rd_ff;
  logic [`ISR_EQ_AW-1:0] eq_wr_ff;
  logic [`ISR_EQ_AW:0] eq_cnt_ff;
  logic eq_pop;
  logic eq_full;
  logic eq_empty;
  assign eq_empty = (eq_cnt_ff == '0);
  assign eq_full = (eq_cnt_ff == (`ISR_EQ_AW+1)'(`ISR_EQ_DEPTH));
  assign eq_pop = rd_err & ~eq_empty;

  // Full queue: last slot becomes the overflow code, older errors kept
  always_ff @(posedge ref_clk)
  begin
    if (err_push && !do_cls)
    begin
      if (eq_full && !eq_pop)
        eq_mem[eq_wr_ff - `ISR_EQ_AW'(1)] <= `ISR_ERR_OVF;
      else
        eq_mem[eq_wr_ff] <= err_code;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eq_rd_ff <= '0;
      eq_wr_ff <= '0;
      eq_cnt_ff <= '0;
    end
    else if (do_cls)
    begin
      eq_rd_ff <= '0;
      eq_wr_ff <= '0;
      eq_cnt_ff <= '0;
    end
    else
    begin
      if (eq_pop)
        eq_rd_ff <= eq_rd_ff + `ISR_EQ_AW'(1);
      if (err_push && (!eq_full || eq_pop))
        eq_wr_ff <= eq_wr_ff + `ISR_EQ_AW'(1);
      if (err_push && !eq_full && !eq_pop)
        eq_cnt_ff <= eq_cnt_ff + (`ISR_EQ_AW+1)'(1);
      else if (eq_pop && !err_push)
        eq_cnt_ff <= eq_cnt_ff - (`ISR_EQ_AW+1)'(1);
    end
  end

  // ****************************************
  // Status byte and service request
  // ****************************************
  logic [7:0] sre_ff;
  logic mav_ff;
  logic oq_prev_ff;
  logic rqs_ff;
  logic master_summary;
  logic [7:0] stb;
  logic [7:0] stb_poll;
  always_comb
  begin
    stb = 8'h00;
    stb[`ISR_S_OPSUM] = operation_summary;
    stb[`ISR_S_EVSUM] = any_en({8'h00, esr_ff}, {8'h00, ese_ff});
    stb[`ISR_S_MSGAV] = mav_ff;
    stb[`ISR_S_QSUM] = any_en(qevt_ff, qen_ff);
    stb[`ISR_S_ERR] = ~eq_empty;
    master_summary = any_en({8'h00, stb}, {8'h00, sre_ff});
    stb[`ISR_S_MASTER] = master_summary;
    stb_poll = stb;
    stb_poll[`ISR_S_MASTER] = rqs_ff;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      sre_ff <= 8'h00;
    else if (is_op(take, cmd, isr_pkg::ISR_WR_SRE))
      sre_ff <= cmd.data[7:0] & 8'hBC;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      oq_prev_ff <= 1'b0;
    else
      oq_prev_ff <= oq_nonempty;
  end

  // A new response raises the bit; clear-status without flush hides the rest
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      mav_ff <= 1'b0;
    else if (oq_nonempty && !oq_prev_ff)
      mav_ff <= 1'b1;
    else if (do_cls || !oq_nonempty)
      mav_ff <= 1'b0;
  end

  // Request flag follows a fresh master summary; a poll drops it
  logic mss_prev_ff;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      mss_prev_ff <= 1'b0;
    else
      mss_prev_ff <= master_summary;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rqs_ff <= 1'b0;
    else if (master_summary && !mss_prev_ff)
      rqs_ff <= 1'b1;
    else if (do_poll || !master_summary)
      rqs_ff <= 1'b0;
  end

  assign srq = rqs_ff & (|sre_ff);

  // ****************************************
  // Blocking waits
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= isr_pkg::ISR_ST_RUN;
    else
    begin
      case (st_ff)
        isr_pkg::ISR_ST_RUN:
          if (is_op(take, cmd, isr_pkg::ISR_WAI))
            st_ff <= isr_pkg::ISR_ST_WAI;
          else if (is_op(take, cmd, isr_pkg::ISR_CPL_Q))
            st_ff <= isr_pkg::ISR_ST_OPCQ;
        isr_pkg::ISR_ST_WAI:
          if (dev_clear || done_wait)
            st_ff <= isr_pkg::ISR_ST_RUN;
        isr_pkg::ISR_ST_OPCQ:
          if (dev_clear || done_wait)
            st_ff <= isr_pkg::ISR_ST_RUN;
        default:
          st_ff <= isr_pkg::ISR_ST_RUN;
      endcase
    end
  end

  // ****************************************
  // Responses and side pulses
  // ****************************************
  logic [15:0] rd_val;
  logic rd_op;
  always_comb
  begin
    rd_op = take;
    rd_val = 16'h0000;
    case (cmd.op)
      isr_pkg::ISR_RD_COND: rd_val = cond;
      isr_pkg::ISR_RD_QEVT: rd_val = qevt_ff;
      isr_pkg::ISR_RD_QEN: rd_val = qen_ff;
      isr_pkg::ISR_RD_FALL: rd_val = fall_ff;
      isr_pkg::ISR_RD_RISE: rd_val = rise_ff;
      isr_pkg::ISR_RD_ESE: rd_val = {8'h00, ese_ff};
      isr_pkg::ISR_RD_ESR: rd_val = {8'h00, esr_ff};
      isr_pkg::ISR_RD_SRE: rd_val = {8'h00, sre_ff};
      isr_pkg::ISR_RD_STB: rd_val = {8'h00, stb};
      isr_pkg::ISR_POLL: rd_val = {8'h00, stb_poll};
      isr_pkg::ISR_RD_ERR: rd_val = eq_empty ? `ISR_ERR_NONE : eq_mem[eq_rd_ff];
      isr_pkg::ISR_RD_RL: rd_val = {14'h0000, rl_state};
      default: rd_op = 1'b0;
    endcase
  end

  logic opcq_done;
  assign opcq_done = (st_ff == isr_pkg::ISR_ST_OPCQ) & done_wait & ~dev_clear;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      rsp_valid <= rd_op | opcq_done;
      if (opcq_done)
        rsp_data <= `ISR_ASCII_ONE;
      else if (rd_op)
        rsp_data <= rd_val;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      operation_summary_evt_clear <= 1'b0;
      oq_flush <= 1'b0;
    end
    else
    begin
      operation_summary_evt_clear <= do_cls;
      oq_flush <= do_cls & cmd.after_term;
    end
  end

  // ****************************************
  // Remote/local state
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rl_state <= isr_pkg::ISR_LOCAL;
    else if (is_op(take, cmd, isr_pkg::ISR_WR_RL))
      rl_state <= isr_pkg::isr_rl_t'(cmd.data[1:0]);
    else if (rl_if_valid)
      rl_state <= rl_if_state;
  end
  assign keys_locked = (rl_state == isr_pkg::ISR_LOCKED);

  // ****************************************
  // Checks
  // ****************************************
  sequence s_opcq_taken;
    is_op(take, cmd, isr_pkg::ISR_CPL_Q) && pending_busy;
  endsequence
  sequence s_in_opcq;
    st_ff == isr_pkg::ISR_ST_OPCQ;
  endsequence
  sequence s_work_ends;
    !pending_busy && !dev_clear;
  endsequence

  chk_questionable_summary_summary: assert property (@(posedge ref_clk) disable iff (!nrst)
    is_op(take, cmd, isr_pkg::ISR_RD_STB) |=>
    rsp_data[`ISR_S_QSUM] == $past(|(qevt_ff & qen_ff)))
    else $error("questionable summary wrong");
  chk_rise_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rise_ff[0] && !cond_prev_ff[0] && cond[0]) |=> qevt_ff[0])
    else $error("rising edge not latched");
  chk_fall_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!fall_ff[1] && !rise_ff[1] && !qevt_ff[1] && !do_cls) |=> !qevt_ff[1])
    else $error("event latched with filters off");
  chk_preset_vals: assert property (@(posedge ref_clk) disable iff (!nrst)
    do_pre |=> (rise_ff == `ISR_PRE_RISE) && (fall_ff == 16'h0000) && (qen_ff == 16'h0000))
    else $error("preset values wrong");
  chk_esr_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_esr && eset == 8'h00) |=> rsp_valid && rsp_data[7:0] == $past(esr_ff) && esr_ff == 0)
    else $error("event register not cleared by read");
  chk_opcq_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_opcq_taken |=> !cmd_ready) else $error("complete query did not block");
  chk_opcq_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_in_opcq ##0 s_work_ends |=>
    rsp_valid && rsp_data == `ISR_ASCII_ONE) else $error("complete query answer wrong");
  chk_srq_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sre_ff == 8'h00) |-> !srq) else $error("service request with zero mask");
  chk_poll_request: assert property (@(posedge ref_clk) disable iff (!nrst)
    (do_poll && master_summary && mss_prev_ff) |=> !rqs_ff && stb[`ISR_S_MASTER])
    else $error("poll handling wrong");
  chk_wait_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff == isr_pkg::ISR_ST_WAI && pending_busy && !dev_clear) |=> !cmd_ready)
    else $error("wait released early");
  chk_err_empty: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_err && eq_empty) |=> rsp_data == 16'h0000) else $error("empty queue not zero");

endmodule : isr_status

// ==== verif/isr_ctrl_model.sv ====
// Remote controller model driving the command port of the status block
`timescale 1ns/1ps
module isr_ctrl_model (
  input wire logic ref_clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic cmd_valid,
  output isr_pkg::isr_cmd_t cmd
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // ************************************************************
  // Command issue
  // ************************************************************
  task automatic issue(input isr_pkg::isr_op_t op, input logic [15:0] data, input logic term);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd.op = op;
    cmd.after_term = term;
    cmd.data = data;
    // Ready only moves on rising edges; a stuck block is left to the bench watchdog
    while (cmd_ready !== 1'b1)
      @(negedge ref_clk);
    @(posedge ref_clk);
  endtask : issue

  task automatic release_bus();
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd.op = isr_pkg::ISR_NOP;
    cmd.after_term = ~cmd.after_term;
    // Released data must not look like a held value
    cmd.data = ~cmd.data;
  endtask : release_bus

  task automatic send(input isr_pkg::isr_op_t op, input logic [15:0] data, input logic term);
    issue(op, data, term);
    release_bus();
  endtask : send

  task automatic ask(input isr_pkg::isr_op_t op, output logic [15:0] rsp);
    int n;
    rsp = 'x;
    n = 0;
    issue(op, 16'h0000, 1'b0);
    release_bus();
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (rsp_valid === 1'b1)
      rsp = rsp_data;
  endtask : ask
endmodule : isr_ctrl_model

// ==== verif/instrument_status_reporting_tb_top.sv ====
// Self-checking testbench of the status reporting block
`timescale 1ns/1ps
`include "isr_cfg.svh"
module instrument_status_reporting_tb_top;
  logic ref_clk;
  logic nrst;
  logic cmd_valid;
  isr_pkg::isr_cmd_t cmd;
  logic cmd_ready;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] questionable_summary_src;
  logic operation_summary;
  logic pending_busy;
  isr_pkg::isr_err_evt_t err_evt;
  logic err_push;
  logic [15:0] err_code;
  logic oq_nonempty;
  logic dev_clear;
  logic rl_if_valid;
  isr_pkg::isr_rl_t rl_if_state;
  logic operation_summary_evt_clear;
  logic oq_flush;
  logic srq;
  logic keys_locked;
  isr_pkg::isr_rl_t rl_state;
  int fail_count = 0;
  int check_count = 0;
  int flush_cnt = 0;
  int oclr_cnt = 0;
  logic [15:0] seed = 16'hE2CF;
  logic [15:0] r, a, b, rf, ff;
  logic [15:0] codes [0:8];

  isr_status uut (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .questionable_summary_src(questionable_summary_src),
    .operation_summary(operation_summary), .pending_busy(pending_busy), .err_evt(err_evt),
    .err_push(err_push), .err_code(err_code), .oq_nonempty(oq_nonempty),
    .dev_clear(dev_clear), .rl_if_valid(rl_if_valid), .rl_if_state(rl_if_state),
    .operation_summary_evt_clear(operation_summary_evt_clear), .oq_flush(oq_flush), .srq(srq),
    .keys_locked(keys_locked), .rl_state(rl_state));

  isr_ctrl_model ctrl (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd(cmd));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (oq_flush === 1'b1)
      flush_cnt++;
    if (operation_summary_evt_clear === 1'b1)
      oclr_cnt++;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [15:0] exp_qevt(input logic [15:0] a0, b0, rise, fall);
    return (((~a0 & b0) & rise) | ((a0 & ~b0) & fall)) & `ISR_Q_DEFINED;
  endfunction : exp_qevt

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input isr_pkg::isr_op_t op, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    ctrl.ask(op, v);
    chk(v & m, e);
  endtask : rd

  task automatic wr(input isr_pkg::isr_op_t op, input logic [15:0] d);
    ctrl.send(op, d, 1'b0);
  endtask : wr

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task automatic evt(input logic [3:0] e);
    @(negedge ref_clk);
    err_evt = e;
    @(negedge ref_clk);
    err_evt = '0;
  endtask : evt

  task automatic push(input logic [15:0] c);
    @(negedge ref_clk);
    err_push = 1'b1;
    err_code = c;
    @(negedge ref_clk);
    err_push = 1'b0;
    err_code = ~c;
  endtask : push

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    #750000;
    fail_count++;
    finish_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    nrst = 1'b0;
    questionable_summary_src = '0;
    operation_summary = 1'b0;
    pending_busy = 1'b0;
    err_evt = '0;
    err_push = 1'b0;
    err_code = '0;
    oq_nonempty = 1'b0;
    dev_clear = 1'b0;
    rl_if_valid = 1'b0;
    rl_if_state = isr_pkg::ISR_LOCAL;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    rd(isr_pkg::ISR_RD_ESR, 16'hFFFF, 16'h0080);
    rd(isr_pkg::ISR_RD_ESR, 16'hFFFF, 16'h0000);
    rd(isr_pkg::ISR_RD_RL, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      evt(4'h8 >> i);
      rd(isr_pkg::ISR_RD_ESR, 16'hFFFF, 16'h0020 >> i);
    end
    wr(isr_pkg::ISR_WR_ESE, 16'h0020);
    rd(isr_pkg::ISR_RD_ESE, 16'hFFFF, 16'h0020);
    evt(4'h1);
    rd(isr_pkg::ISR_RD_STB, 16'h0020, 16'h0000);
    evt(4'h8);
    rd(isr_pkg::ISR_RD_STB, 16'h0020, 16'h0020);
    rd(isr_pkg::ISR_RD_ESR, 16'hFFFF, 16'h0024);
    rd(isr_pkg::ISR_RD_STB, 16'h0020, 16'h0000);
    // Random edge filter traffic, first pass a hand-picked all-rising corner
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      a = seed;
      seed = lfsr(seed);
      b = seed;
      seed = lfsr(seed);
      rf = seed;
      seed = lfsr(seed);
      ff = seed;
      if (i == 0)
      begin
        a = 16'h0000;
        b = 16'hFFFF;
        rf = 16'hFFFF;
      end
      wr(isr_pkg::ISR_WR_RISE, rf);
      wr(isr_pkg::ISR_WR_FALL, ff);
      rd(isr_pkg::ISR_RD_RISE, 16'hFFFF, rf & `ISR_Q_DEFINED);
      questionable_summary_src = a;
      idle(3);
      rd(isr_pkg::ISR_RD_COND, 16'hFFFF, a & `ISR_Q_DEFINED);
      ctrl.ask(isr_pkg::ISR_RD_QEVT, r);
      questionable_summary_src = b;
      idle(3);
      rd(isr_pkg::ISR_RD_QEVT, 16'hFFFF, exp_qevt(a, b, rf, ff));
      rd(isr_pkg::ISR_RD_QEVT, 16'hFFFF, 16'h0000);
    end
    questionable_summary_src = '0;
    wr(isr_pkg::ISR_WR_RISE, 16'h0617);
    wr(isr_pkg::ISR_WR_FALL, 16'h0010);
    ctrl.ask(isr_pkg::ISR_RD_QEVT, r);
    questionable_summary_src = 16'h0010;
    wr(isr_pkg::ISR_WR_QEN, 16'h0001);
    rd(isr_pkg::ISR_RD_STB, 16'h0008, 16'h0000);
    wr(isr_pkg::ISR_WR_QEN, 16'h0010);
    rd(isr_pkg::ISR_RD_STB, 16'h0048, 16'h0008);
    rd(isr_pkg::ISR_RD_STB, 16'h0048, 16'h0008);
    chk({15'h0000, srq}, 16'h0000);
    wr(isr_pkg::ISR_WR_SRE, 16'h0008);
    // Request flag needs one more edge after the mask lands
    idle(1);
    chk({15'h0000, srq}, 16'h0001);
    rd(isr_pkg::ISR_RD_SRE, 16'hFFFF, 16'h0008);
    rd(isr_pkg::ISR_RD_STB, 16'h0048, 16'h0048);
    rd(isr_pkg::ISR_POLL, 16'h0048, 16'h0048);
    chk({15'h0000, srq}, 16'h0000);
    rd(isr_pkg::ISR_RD_STB, 16'h0040, 16'h0040);
    rd(isr_pkg::ISR_RD_QEVT, 16'hFFFF, 16'h0010);
    rd(isr_pkg::ISR_RD_STB, 16'h0048, 16'h0000);
    wr(isr_pkg::ISR_WR_SRE, 16'h0000);
    oq_nonempty = 1'b1;
    operation_summary = 1'b1;
    rd(isr_pkg::ISR_RD_STB, 16'h0090, 16'h0090);
    oq_nonempty = 1'b0;
    operation_summary = 1'b0;
    rd(isr_pkg::ISR_RD_STB, 16'h0090, 16'h0000);
    // Error queue order, empty code and overflow marker
    for (int i = 0; i < 9; i++)
    begin
      seed = lfsr(seed);
      codes[i] = seed | 16'h8000;
    end
    for (int i = 0; i < 3; i++)
      push(codes[i]);
    for (int i = 0; i < 3; i++)
      rd(isr_pkg::ISR_RD_ERR, 16'hFFFF, codes[i]);
    rd(isr_pkg::ISR_RD_ERR, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 9; i++)
      push(codes[i]);
    rd(isr_pkg::ISR_RD_STB, 16'h0004, 16'h0004);
    for (int i = 0; i < 7; i++)
      rd(isr_pkg::ISR_RD_ERR, 16'hFFFF, codes[i]);
    rd(isr_pkg::ISR_RD_ERR, 16'hFFFF, -16'sd350);
    // Clear-status with and without a preceding terminator
    evt(4'h8);
    push(codes[0]);
    questionable_summary_src = 16'h0000;
    idle(3);
    ctrl.send(isr_pkg::ISR_CLS, 16'h0000, 1'b0);
    idle(2);
    chk(flush_cnt[15:0], 16'h0000);
    chk(oclr_cnt[15:0], 16'h0001);
    rd(isr_pkg::ISR_RD_ESR, 16'hFFFF, 16'h0000);
    rd(isr_pkg::ISR_RD_QEVT, 16'hFFFF, 16'h0000);
    rd(isr_pkg::ISR_RD_ERR, 16'hFFFF, 16'h0000);
    oq_nonempty = 1'b1;
    idle(2);
    ctrl.send(isr_pkg::ISR_CLS, 16'h0000, 1'b1);
    idle(2);
    chk(flush_cnt[15:0], 16'h0001);
    rd(isr_pkg::ISR_RD_STB, 16'h0010, 16'h0000);
    oq_nonempty = 1'b0;
    wr(isr_pkg::ISR_WR_QEN, 16'h0617);
    wr(isr_pkg::ISR_WR_RISE, 16'h0000);
    wr(isr_pkg::ISR_PRESET, 16'h0000);
    rd(isr_pkg::ISR_RD_RISE, 16'hFFFF, 16'h7FFF);
    rd(isr_pkg::ISR_RD_FALL, 16'hFFFF, 16'h0000);
    rd(isr_pkg::ISR_RD_QEN, 16'hFFFF, 16'h0000);
    // Completion tracking while overlapped work is pending
    pending_busy = 1'b1;
    wr(isr_pkg::ISR_CPL, 16'h0000);
    chk({15'h0000, cmd_ready}, 16'h0001);
    idle(5);
    rd(isr_pkg::ISR_RD_ESR, 16'hFFFF, 16'h0000);
    pending_busy = 1'b0;
    idle(3);
    rd(isr_pkg::ISR_RD_ESR, 16'hFFFF, 16'h0001);
    pending_busy = 1'b1;
    fork
      ctrl.ask(isr_pkg::ISR_CPL_Q, r);
      begin
        idle(4);
        chk({15'h0000, cmd_ready}, 16'h0000);
        pending_busy = 1'b0;
      end
    join
    chk(r, 16'h0031);
    pending_busy = 1'b1;
    wr(isr_pkg::ISR_WAI, 16'h0000);
    idle(6);
    chk({15'h0000, cmd_ready}, 16'h0000);
    dev_clear = 1'b1;
    idle(1);
    dev_clear = 1'b0;
    idle(3);
    chk({15'h0000, cmd_ready}, 16'h0001);
    pending_busy = 1'b0;
    // Remote/local: latest changer decides
    wr(isr_pkg::ISR_WR_RL, 16'h0001);
    rd(isr_pkg::ISR_RD_RL, 16'hFFFF, 16'h0001);
    rl_if_valid = 1'b1;
    rl_if_state = isr_pkg::ISR_LOCKED;
    idle(1);
    rl_if_valid = 1'b0;
    idle(1);
    chk({14'h0000, rl_state, keys_locked}, 16'h0005);
    wr(isr_pkg::ISR_WR_RL, 16'h0000);
    chk({14'h0000, rl_state, keys_locked}, 16'h0000);
    finish_test();
  end
endmodule : instrument_status_reporting_tb_top
